// ===== cca_defs.svh
// constants for the checksum / crc accelerator: offsets, fields, seeds
// assumes an 8-bit register port with a 16-bit byte address
`ifndef CCA_DEFS_SVH
`define CCA_DEFS_SVH

// register byte addresses
`define CCA_ADDR_W 16
`define CCA_OFF_CONFIG 16'hA078
`define CCA_OFF_DATA0 16'hA07C
`define CCA_OFF_DATA1 16'hA07D
`define CCA_OFF_DATA2 16'hA07E
`define CCA_OFF_DATA3 16'hA07F

// config field positions
`define CCA_CFG_WIDTH_HI 7
`define CCA_CFG_WIDTH_LO 6
`define CCA_CFG_REVERSE 5
`define CCA_CFG_CARRY_DISCARD 4
`define CCA_CFG_SEED 3
`define CCA_CFG_FUNC_HI 2
`define CCA_CFG_FUNC_LO 0
`define CCA_CFG_BUSY 0
`define CCA_CFG_RESET 8'h00

// default seeds and generator polynomials (top bit implied)
`define CCA_SEED_SUM 32'h0000_0000
`define CCA_SEED_CRC16 32'h0000_FFFF
`define CCA_SEED_CRC32 32'hFFFF_FFFF
`define CCA_POLY_CRC16A 32'h0000_8005
`define CCA_POLY_CRC16B 32'h0000_1021
`define CCA_POLY_CRC32 32'h04C1_1DB7

// result masks
`define CCA_MASK_8 32'h0000_00FF
`define CCA_MASK_16 32'h0000_FFFF
`define CCA_MASK_32 32'hFFFF_FFFF

// buffering
`define CCA_FIFO_DEPTH 32

`endif

// ===== cca_pkg.sv
// types shared by the accelerator files
// defines its own selector and state codes; the other numeric constants live in cca_defs.svh
package cca_pkg;

    // function selector codes
    typedef enum logic [2:0] {
        CCA_FN_OFF = 3'b000,
        CCA_FN_SUM8 = 3'b001,
        CCA_FN_SUM32 = 3'b010,
        CCA_FN_CRC16A = 3'b011,
        CCA_FN_CRC16B = 3'b100,
        CCA_FN_CRC32 = 3'b101,
        CCA_FN_RSVD = 3'b110,
        CCA_FN_CLEAR = 3'b111
    } cca_func_t;

    // input width selector codes
    typedef enum logic [1:0] {
        CCA_W8 = 2'b00,
        CCA_W16 = 2'b01,
        CCA_W24 = 2'b10,
        CCA_W32 = 2'b11
    } cca_width_t;

    // engine states
    typedef enum logic {
        CCA_ST_IDLE = 1'b0,
        CCA_ST_RUN = 1'b1
    } cca_state_t;

endpackage : cca_pkg

// ===== cca_accel.sv
// checksum / crc accelerator: entry fifo and the engine top level
// assumes a cpu register port, one access per cycle, synchronous inputs
//
// Behaviour
// [RULE1] one entry takes one cycle for 8-bit, two for 16-bit, four for 32-bit
// [RULE2] width selector 00/01/10/11 picks 8/16/24/32-bit entries
// [RULE3] reverse set mirrors data bits across the selected width
// [RULE4] seed loads and result reads never get bit reversal
// [RULE5] checksum adds previous carry unless carry discard is set
// [RULE6] with seed bit set, data port writes load the seed
// [RULE7] function 000 disables the engine and freezes its state
// [RULE8] function 001 is 8-bit checksum, 010 is 32-bit checksum
// [RULE9] function 011 is crc-16 with polynomial 0x8005
// [RULE10] function 100 is crc-16 with polynomial 0x1021
// [RULE11] function 101 is crc-32 0x104C11DB7; 110 is reserved, does nothing
// [RULE12] writing 111 clears state and reloads the default seed
// [RULE13] software selects a function, then writes 111, before data
// [RULE14] config status bit reads 1 while a calculation is pending
// [RULE15] software writes high bytes before the low byte
// [RULE16] low byte write completes the entry and starts the calculation
// [RULE17] data byte reads return the running result, msb in byte 3
// [RULE18] checksums add each word modulo the checksum width
// [RULE19] crc shifts msb first, no final inversion, at most 16 bits a cycle

`include "cca_defs.svh"

// simple synchronous fifo, registered full and empty flags
module cca_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = `CCA_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // pointers wrap naturally, so depth must be a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("cca_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic full_q;
    logic empty_q;
    logic push;
    logic pop;
    logic [AW:0] count_d;

    assign push = in_valid & ~full_q;
    assign pop = out_ready & ~empty_q;
    assign out_valid = ~empty_q;
    assign out_data = mem[rd_ptr_q];

    // occupancy after this cycle's push and pop
    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // storage array, no reset needed on the data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // pointers and flags; flush drops everything queued
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
            in_ready <= 1'b1;
        end else if (flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_d;
            full_q <= (count_d == DEPTH[AW:0]);
            empty_q <= (count_d == '0);
            in_ready <= (count_d != DEPTH[AW:0]);
        end
    end

endmodule : cca_fifo

// accelerator top: register port, entry capture, checksum and crc engine
module cca_accel #(
    parameter int FIFO_DEPTH = `CCA_FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [`CCA_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // entry flow control
    output logic entry_ready
);
    localparam int EW = 35;

    // bytes in one entry for a width code
    function automatic logic [2:0] width_bytes(input logic [1:0] w);
        width_bytes = {1'b0, w} + 3'd1;
    endfunction : width_bytes

    // mirror the low bits of a word across the selected width
    function automatic logic [31:0] mirror(input logic [31:0] v,
                                           input logic [1:0] w);
        logic [31:0] r;
        int n;
        r = '0;
        n = 8 * (int'(w) + 1);
        for (int i = 0; i < 32; i++) begin
            if (i < n) begin
                r[n-1-i] = v[i];
            end
        end
        mirror = r;
    endfunction : mirror

    // result width mask for a function
    function automatic logic [31:0] result_mask(input logic [2:0] f);
        unique case (f)
            3'b001: result_mask = `CCA_MASK_8;
            3'b011, 3'b100: result_mask = `CCA_MASK_16;
            default: result_mask = `CCA_MASK_32;
        endcase
    endfunction : result_mask

    // default seed for a function
    function automatic logic [31:0] default_seed(input logic [2:0] f);
        unique case (f)
            3'b011, 3'b100: default_seed = `CCA_SEED_CRC16;
            3'b101: default_seed = `CCA_SEED_CRC32;
            default: default_seed = `CCA_SEED_SUM;
        endcase
    endfunction : default_seed

    // eight crc steps, msb first, for a 16- or 32-bit register
    function automatic logic [31:0] crc_byte(input logic [31:0] c_in,
                                             input logic [7:0] d,
                                             input logic [2:0] f);
        logic [31:0] c;
        logic [31:0] poly;
        logic fb;
        logic narrow;
        c = c_in;
        narrow = (f != 3'b101);
        poly = (f == 3'b011) ? `CCA_POLY_CRC16A :
               (f == 3'b100) ? `CCA_POLY_CRC16B : `CCA_POLY_CRC32;
        for (int i = 7; i >= 0; i--) begin
            fb = (narrow ? c[15] : c[31]) ^ d[i];
            c = {c[30:0], 1'b0};
            if (fb) begin
                c = c ^ poly;
            end
            if (narrow) begin
                c[31:16] = 16'h0000;
            end
        end
        crc_byte = c;
    endfunction : crc_byte

    // configuration fields
    logic [1:0] width_q;
    logic reverse_q;
    logic carry_discard_q;
    logic seed_q;
    logic [2:0] func_q;
    logic clear_q;
    // upper bytes of the entry being assembled
    logic [31:8] hold_q;
    // engine state
    cca_pkg::cca_state_t state_q;
    logic [31:0] acc_q;
    logic carry_q;
    logic [31:0] shift_q;
    logic [2:0] rem_q;
    logic [7:0] rdata_q;

    // fifo wiring
    logic push_valid;
    logic [EW-1:0] push_data;
    logic fifo_in_ready;
    logic pop_valid;
    logic pop_ready;
    logic [EW-1:0] pop_data;
    logic engine_on;
    logic busy;
    logic [31:0] entry_word;

    logic wr_cfg;
    logic wr_low;

    assign wr_cfg = reg_wr && (reg_addr == `CCA_OFF_CONFIG);
    assign wr_low = reg_wr && (reg_addr == `CCA_OFF_DATA0);

    // engine runs only for a defined function
    assign engine_on = (func_q >= 3'b001) && (func_q <= 3'b101); // [RULE7] [RULE11]

    // config register; 111 triggers a clear and keeps the chosen function
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            width_q <= 2'b00;
            reverse_q <= 1'b0;
            carry_discard_q <= 1'b0;
            seed_q <= 1'b0;
            func_q <= 3'b000;
            clear_q <= 1'b0;
        end else begin
            clear_q <= 1'b0;
            if (wr_cfg) begin
                width_q <= reg_wdata[`CCA_CFG_WIDTH_HI:`CCA_CFG_WIDTH_LO]; // [RULE2]
                reverse_q <= reg_wdata[`CCA_CFG_REVERSE];
                carry_discard_q <= reg_wdata[`CCA_CFG_CARRY_DISCARD];
                seed_q <= reg_wdata[`CCA_CFG_SEED];
                if (reg_wdata[`CCA_CFG_FUNC_HI:`CCA_CFG_FUNC_LO] == 3'b111) begin
                    clear_q <= 1'b1; // [RULE12]
                end else begin
                    func_q <= reg_wdata[`CCA_CFG_FUNC_HI:`CCA_CFG_FUNC_LO];
                end
            end
        end
    end

    // upper data bytes wait here until the low byte arrives
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= 24'h00_0000;
        end else if (reg_wr) begin
            if (reg_addr == `CCA_OFF_DATA1) begin
                hold_q[15:8] <= reg_wdata;
            end
            if (reg_addr == `CCA_OFF_DATA2) begin
                hold_q[23:16] <= reg_wdata;
            end
            if (reg_addr == `CCA_OFF_DATA3) begin
                hold_q[31:24] <= reg_wdata;
            end
        end
    end

    // entry word: seeds keep natural order, data may be mirrored
    always_comb begin
        entry_word = {hold_q, reg_wdata}; // [RULE16]
        if (!seed_q && reverse_q) begin
            entry_word = mirror({hold_q, reg_wdata}, width_q); // [RULE3] [RULE4]
        end
    end

    // entries queue with their seed flag and width; writes while the
    // engine is off or the queue is full are dropped
    assign push_valid = wr_low && engine_on && !clear_q; // [RULE16]
    assign push_data = {seed_q, width_q, entry_word}; // [RULE6]

    cca_fifo #(
        .WIDTH(EW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .resetn(resetn),
        .flush(clear_q),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_data)
    );

    // the engine takes a new entry only when idle and enabled
    assign pop_ready = (state_q == cca_pkg::CCA_ST_IDLE) && engine_on
                       && !clear_q; // [RULE7]

    // engine: checksums add the whole word on the pop cycle; crc takes the first byte then, one more byte each cycle after
    always_ff @(posedge core_clk or negedge resetn) begin
        logic [2:0] nb;
        logic [31:0] word;
        logic [32:0] sum;
        logic [31:0] cin;
        if (!resetn) begin
            state_q <= cca_pkg::CCA_ST_IDLE;
            acc_q <= 32'h0000_0000;
            carry_q <= 1'b0;
            shift_q <= 32'h0000_0000;
            rem_q <= 3'd0;
        end else if (clear_q) begin
            state_q <= cca_pkg::CCA_ST_IDLE;
            acc_q <= default_seed(func_q); // [RULE12]
            carry_q <= 1'b0;
            rem_q <= 3'd0;
        end else if (!engine_on) begin
            // frozen: the clock is gated in the real part
            state_q <= state_q; // [RULE7]
        end else if (state_q == cca_pkg::CCA_ST_RUN) begin
            if (func_q >= 3'b011) begin
                acc_q <= crc_byte(acc_q, shift_q[31:24], func_q); // [RULE19]
            end
            shift_q <= {shift_q[23:0], 8'h00};
            rem_q <= rem_q - 3'd1;
            if (rem_q == 3'd1) begin
                state_q <= cca_pkg::CCA_ST_IDLE; // [RULE1]
            end
        end else if (pop_valid) begin
            nb = width_bytes(pop_data[33:32]);
            word = pop_data[31:0] & ((nb == 3'd4) ? 32'hFFFF_FFFF :
                   ((32'h0000_0001 << {nb, 3'b000}) - 32'h0000_0001));
            if (pop_data[34]) begin
                acc_q <= pop_data[31:0] & result_mask(func_q); // [RULE6]
                carry_q <= 1'b0;
            end else if (func_q <= 3'b010) begin
                cin = {31'h0, carry_q & ~carry_discard_q}; // [RULE5]
                if (func_q == 3'b001) begin
                    sum = {1'b0, acc_q & `CCA_MASK_8} + {1'b0, word}
                          + {1'b0, cin};
                    acc_q <= sum[31:0] & `CCA_MASK_8; // [RULE8] [RULE18]
                    carry_q <= (sum[32:8] != 25'h000_0000);
                end else begin
                    sum = {1'b0, acc_q} + {1'b0, word} + {1'b0, cin};
                    acc_q <= sum[31:0]; // [RULE8] [RULE18]
                    carry_q <= sum[32];
                end
                if (nb != 3'd1) begin
                    state_q <= cca_pkg::CCA_ST_RUN; // [RULE1]
                    rem_q <= nb - 3'd1;
                end
            end else begin
                // align the entry to the top so bytes leave msb first
                word = word << {(3'd4 - nb), 3'b000};
                acc_q <= crc_byte(acc_q, word[31:24], func_q); // [RULE9] [RULE10] [RULE11]
                shift_q <= {word[23:0], 8'h00};
                if (nb != 3'd1) begin
                    state_q <= cca_pkg::CCA_ST_RUN; // [RULE1]
                    rem_q <= nb - 3'd1;
                end
            end
        end
    end

    // busy while anything is queued or in flight
    assign busy = pop_valid || (state_q == cca_pkg::CCA_ST_RUN); // [RULE14]

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `CCA_OFF_CONFIG: rdata_q <= {width_q, reverse_q,
                    carry_discard_q, seed_q, 2'b00, busy}; // [RULE14]
                `CCA_OFF_DATA0: rdata_q <= acc_q[7:0]; // [RULE17]
                `CCA_OFF_DATA1: rdata_q <= acc_q[15:8]; // [RULE17]
                `CCA_OFF_DATA2: rdata_q <= acc_q[23:16]; // [RULE17]
                `CCA_OFF_DATA3: rdata_q <= acc_q[31:24]; // [RULE17]
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    // registered not-full flag of the queue
    assign entry_ready = fifo_in_ready;

endmodule : cca_accel

// ===== cca_accel_sva.sv
// checker for the accelerator register port and entry flow flag
// assumes it is bound to cca_accel and sees only that module's ports
`include "cca_defs.svh"
module cca_accel_sva #(
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [`CCA_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // entry flow control
    input wire logic entry_ready
);
    logic [7:0] cfg_q;
    logic [2:0] fn_q;
    logic clr_q;
    logic seen_q;
    logic cfg_wr;
    logic low_wr;
    logic cfg_rd;
    logic mapped;
    logic big_ok;

    // decoded strobes; a 32-bit entry the engine has to take
    assign cfg_wr = reg_wr && reg_addr == `CCA_OFF_CONFIG;
    assign cfg_rd = reg_rd && reg_addr == `CCA_OFF_CONFIG;
    assign low_wr = reg_wr && reg_addr == `CCA_OFF_DATA0;
    assign mapped = reg_addr == `CCA_OFF_CONFIG
        || (reg_addr >= `CCA_OFF_DATA0 && reg_addr <= `CCA_OFF_DATA3);
    assign big_ok = low_wr && entry_ready && !clr_q && !cfg_q[3]
        && cfg_q[7:6] == 2'b11 && fn_q >= 3'b001 && fn_q <= 3'b101;

    // shadow of config writes; clear code keeps the stored function
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= 8'h00;
            fn_q <= 3'b000;
            clr_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            clr_q <= cfg_wr && reg_wdata[2:0] == 3'b111;
            if (cfg_wr) cfg_q <= reg_wdata;
            if (cfg_wr && reg_wdata[2:0] != 3'b111) fn_q <= reg_wdata[2:0];
            if (reg_wr) seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    idle_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    hole_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    cfg_rsvd_a: assert property (cfg_rd |=> reg_rdata[2:1] == 2'b00)
        else $error("config reserved bits not zero");
    cfg_fields_a: assert property (cfg_rd |=> reg_rdata[7:3] == cfg_q[7:3])
        else $error("config fields differ from last write");
    busy_entry_a: assert property (big_ok ##2 cfg_rd |=> reg_rdata[0])
        else $error("busy low during a 32-bit entry");
    reset_read_a: assert property (reg_rd && !seen_q |=> reg_rdata == 8'h00)
        else $error("register not at reset value");
    ready_start_a: assert property ($rose(resetn) |-> entry_ready)
        else $error("queue not ready after reset");
    ready_fall_a: assert property ($fell(entry_ready) |-> $past(low_wr) || $past(low_wr, 2))
        else $error("queue filled without an entry");
endmodule : cca_accel_sva

bind cca_accel cca_accel_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
    .core_clk(core_clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .entry_ready(entry_ready)
);

// ===== cca_cpu_model.sv
// cpu-side model: register port master of the accelerator
// assumes clk is the core clock and reset is sequenced by the bench
`include "cca_defs.svh"
module cca_cpu_model (
    // clock
    input wire logic clk,
    // register port
    output logic [`CCA_ADDR_W-1:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata,
    // entry queue room
    input wire logic ready
);
    // quiet bus at time zero
    initial begin
        addr = '0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // one write; ok is the queue room seen at the taking edge
    task automatic wr_b(input logic [15:0] a, input logic [7:0] d,
                        output logic ok);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        ok = ready;
        wr <= 1'b0;
        wdata <= ~d; // no stale data left looking valid
    endtask : wr_b

    // one read; data exist only in the cycle after the strobe
    task automatic rd_b(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rd_b

    // pick the function first, then clear, before any data
    task automatic cfg_clr(input logic [7:0] c);
        logic ok;
        wr_b(`CCA_OFF_CONFIG, c, ok);
        wr_b(`CCA_OFF_CONFIG, {c[7:3], 3'b111}, ok);
    endtask : cfg_clr

    // one entry: upper bytes first, the low byte commits it
    task automatic entry(input logic [1:0] w, input logic [31:0] v,
                         output logic ok);
        for (int b = 3; b >= 1; b--) begin
            if (b <= int'(w)) begin
                wr_b(16'(`CCA_OFF_DATA0 + b), v[8*b +: 8], ok);
            end
        end
        wr_b(`CCA_OFF_DATA0, v[7:0], ok);
    endtask : entry

    // whole result, top byte first
    task automatic rd32(output logic [31:0] r);
        logic [7:0] d;
        for (int b = 3; b >= 0; b--) begin
            rd_b(16'(`CCA_OFF_DATA0 + b), d);
            r[8*b +: 8] = d;
        end
    endtask : rd32
endmodule : cca_cpu_model

// ===== cca_accel_tb_top.sv
// self-checking bench for the checksum / crc accelerator
// assumes the design, checker and cpu model files are compiled first
`include "cca_defs.svh"
module cca_accel_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk;
    logic resetn;
    logic [`CCA_ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic entry_ready;
    int err_total;
    int n_tests;
    logic [31:0] m_acc;
    logic m_cy;
    logic [7:0] m_cfg;

    // small queue so that it fills quickly
    cca_accel #(.FIFO_DEPTH(4)) u_dut (
        .core_clk(core_clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .entry_ready(entry_ready)
    );
    cca_cpu_model u_cpu (
        .clk(core_clk),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .wr(reg_wr),
        .rd(reg_rd),
        .rdata(reg_rdata),
        .ready(entry_ready)
    );

    // 50 MHz core clock
    always #10 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    function automatic logic [31:0] rmask(input logic [2:0] f);
        if (f == 3'b001) return `CCA_MASK_8;
        if (f == 3'b011 || f == 3'b100) return `CCA_MASK_16;
        return `CCA_MASK_32;
    endfunction : rmask

    // reference result update for one accepted entry
    task automatic model(input logic [31:0] v);
        int nb;
        logic [31:0] w;
        logic [32:0] s;
        logic fb;
        nb = 8 * (int'(m_cfg[7:6]) + 1);
        w = 32'h0000_0000;
        for (int i = 0; i < nb; i++) begin
            w[i] = m_cfg[5] ? v[nb-1-i] : v[i];
        end
        if (m_cfg[3]) begin
            m_acc = v & rmask(m_cfg[2:0]);
        end else if (m_cfg[2:0] <= 3'b010) begin
            s = {1'b0, m_acc} + {1'b0, w} + {32'h0, m_cy & ~m_cfg[4]};
            m_cy = s > {1'b0, rmask(m_cfg[2:0])};
            m_acc = s[31:0] & rmask(m_cfg[2:0]);
        end else begin
            for (int i = nb - 1; i >= 0; i--) begin
                fb = (m_cfg[2:0] == 3'b101 ? m_acc[31] : m_acc[15]) ^ w[i];
                m_acc = (m_acc << 1) & rmask(m_cfg[2:0]);
                if (fb) m_acc = m_acc ^ (m_cfg[2:0] == 3'b011 ? `CCA_POLY_CRC16A
                    : m_cfg[2:0] == 3'b100 ? `CCA_POLY_CRC16B : `CCA_POLY_CRC32);
            end
        end
    endtask : model

    task automatic setup(input logic [7:0] c);
        m_cfg = c;
        u_cpu.cfg_clr(c);
        m_cy = 1'b0;
        m_acc = `CCA_SEED_SUM;
        if (c[2:0] == 3'b011 || c[2:0] == 3'b100) m_acc = `CCA_SEED_CRC16;
        if (c[2:0] == 3'b101) m_acc = `CCA_SEED_CRC32;
    endtask : setup

    task automatic put(input logic [31:0] v);
        logic ok;
        u_cpu.entry(m_cfg[7:6], v, ok);
        if (ok) model(v);
    endtask : put

    // bounded wait for the busy flag to drop
    task automatic wait_idle();
        logic [7:0] d;
        for (int i = 0; i < 100; i++) begin
            u_cpu.rd_b(`CCA_OFF_CONFIG, d);
            if (d[0] === 1'b0) return;
        end
        err_total++;
        stop_test();
    endtask : wait_idle

    task automatic res_chk();
        logic [31:0] r;
        wait_idle();
        u_cpu.rd32(r);
        chk(r, m_acc);
    endtask : res_chk

    // reset values, unmapped holes and an ignored write
    task automatic t_reset();
        logic [7:0] d;
        logic ok;
        for (int a = 'hA078; a <= 'hA07F; a++) begin
            u_cpu.rd_b(16'(a), d);
            chk({24'h0, d}, 32'h0);
        end
        u_cpu.wr_b(16'hA07A, 8'hFF, ok);
        u_cpu.rd_b(`CCA_OFF_CONFIG, d);
        chk({24'h0, d}, 32'h0);
        $display("reset test done");
    endtask : t_reset

    // every function at every width; reversal and carry discard follow width bits 0 and 1
    task automatic t_modes();
        for (int f = 1; f <= 5; f++) begin
            for (int w = 0; w < 4; w++) begin
                setup({2'(w), w[0], w[1], 1'b0, 3'(f)});
                for (int k = 0; k < 3; k++) begin
                    put(32'hF1E2_D3C4 ^ (32'(k) * 32'h1357_9BDF));
                end
                res_chk();
            end
        end
        $display("modes test done");
    endtask : t_modes

    // seed load ignores reversal, then data continues from it
    task automatic t_seed();
        logic ok;
        setup(8'b1110_1011);
        put(32'h1234_ABCD);
        res_chk();
        m_cfg = 8'b1110_0011;
        u_cpu.wr_b(`CCA_OFF_CONFIG, m_cfg, ok);
        put(32'h0000_00A5);
        res_chk();
        $display("seed test done");
    endtask : t_seed

    // reserved and off codes leave the result alone
    task automatic t_freeze();
        logic ok;
        logic [31:0] r;
        setup(8'b0000_0100);
        put(32'h0000_0037);
        wait_idle();
        for (int f = 6; f >= 0; f -= 6) begin
            u_cpu.wr_b(`CCA_OFF_CONFIG, 8'(f), ok);
            u_cpu.wr_b(`CCA_OFF_DATA0, 8'h99, ok);
            u_cpu.rd32(r);
            chk(r, m_acc);
        end
        $display("freeze test done");
    endtask : t_freeze

    // busy length per width: one cycle per data byte
    task automatic t_timing();
        logic [7:0] d;
        for (int w = 0; w < 4; w++) begin
            setup({2'(w), 3'b000, 3'b101});
            if (w > 0) begin
                put(32'hA5C3_0F96);
                u_cpu.rd_b(`CCA_OFF_CONFIG, d);
                chk({31'h0, d[0]}, 32'h1);
                wait_idle();
            end
            put(32'h5A3C_F069);
            repeat (w) @(posedge core_clk);
            u_cpu.rd_b(`CCA_OFF_CONFIG, d);
            chk({31'h0, d[0]}, 32'h0);
            res_chk();
        end
        $display("timing test done");
    endtask : t_timing

    // low-byte only entries outrun the 32-bit engine and fill the queue
    task automatic t_fill();
        logic ok;
        int n_ref;
        n_ref = 0;
        setup({2'b11, 3'b000, 3'b010});
        put(32'h8765_4321);
        for (int i = 0; i < 12; i++) begin
            u_cpu.wr_b(`CCA_OFF_DATA0, 8'(i * 37), ok);
            if (ok) model({24'h87_6543, 8'(i * 37)});
            else n_ref++;
        end
        chk(32'(n_ref > 0), 32'h1);
        res_chk();
        $display("fill test done");
    endtask : t_fill

    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        err_total = 0;
        n_tests = 0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_modes();
        t_seed();
        t_freeze();
        t_timing();
        t_fill();
        stop_test();
    end
endmodule : cca_accel_tb_top
